// >>> verif/status_poller.sv
// avalon-mm polling master standing in for the operator interface
`timescale 1ns/100ps
`default_nettype none
module status_poller (
    // clock
    input  wire logic        clk_i,
    // avalon-mm master side
    output logic      [4:0]  address_o,
    output logic             read_o,
    output logic             write_o,
    output logic      [31:0] writedata_o,
    input  wire logic [31:0] readdata_i,
    input  wire logic        waitrequest_i,
    input  wire logic [1:0]  response_i
);
    initial begin
        address_o   = 5'h1F;
        read_o      = 1'b0;
        write_o     = 1'b0;
        writedata_o = 32'h0000_0000;
    end

    // one transfer: the request stands until waitrequest is seen low at a rising edge;
    // values read right at the edge are those the slave's flops held before it
    task automatic access(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                          output logic [31:0] rd, output logic [1:0] rsp);
        @(posedge clk_i);
        address_o   <= a;
        writedata_o <= wd;
        read_o      <= !wr;
        write_o     <= wr;
        do begin
            @(posedge clk_i);
        end while (waitrequest_i !== 1'b0);
        rd  = readdata_i;
        rsp = response_i;
        // released lines show the inverse, never the stale value
        read_o      <= 1'b0;
        write_o     <= 1'b0;
        address_o   <= ~a;
        writedata_o <= ~wd;
    endtask : access
endmodule : status_poller
`default_nettype wire

// >>> verif/test_module_status_word_bank.sv
// self-checking bench for the module status word bank
`timescale 1ns/100ps
`default_nettype none
module test_module_status_word_bank;
    import status_word_pkg::*;
    logic        ref_clk, rst_b, rd_s, wr_s, done, strobe, clear;
    logic [4:0]  adr;
    logic [31:0] wdat, rdat, d;
    logic [1:0]  wait_rsp, rsp, mode;
    logic        wreq;
    logic [6:0]  hl;
    logic [7:0]  code, cause, c;
    logic [13:0] block;
    logic [15:0] exp_q;
    int          n_fail, samples_checked, blk;
    logic [7:0]  codes [11] = '{ERR_NVM, ERR_NVM, ERR_NVM, ERR_NVM, ERR_AIREF, ERR_MISSING,
                                ERR_UNDEF, ERR_DTYPE, ERR_TRIP, ERR_CFG_OLD, ERR_DRAM_OLD};
    logic [7:0]  causes [4] = '{NVM_WRITE, NVM_CSUM, NVM_BADDATA, NVM_RSTWR};
    logic [4:0]  ofs [4] = '{5'h00, 5'h08, 5'h0C, OFS_QUAL_LO};

    module_status_word_bank uut (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .avs_address_i(adr),
        .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdat),
        .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
        .avs_response_o(wait_rsp), .mode_i(mode), .exec_pass_done_i(done),
        .backup_bad_i(hl[6]), .remote_io_bad_i(hl[5]), .local_io_bad_i(hl[4]),
        .online_cfg_i(hl[3]), .nvm_csum_fail_i(hl[2]), .nvm_default_i(hl[1]),
        .station_bad_i(hl[0]), .err_strobe_i(strobe), .err_code_i(code),
        .err_cause_i(cause), .err_block_i(block), .err_clear_i(clear));
    status_poller p (.clk_i(ref_clk), .address_o(adr), .read_o(rd_s), .write_o(wr_s),
        .writedata_o(wdat), .readdata_i(rdat), .waitrequest_i(wreq), .response_i(wait_rsp));

    // block numbers go out as four bcd digits
    function automatic logic [15:0] bcd16(int n);
        return {4'(n / 1000), 4'(n / 100 % 10), 4'(n / 10 % 10), 4'(n % 10)};
    endfunction : bcd16

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic rd(input logic [4:0] a);
        p.access(1'b0, a, 32'h0000_0000, d, rsp);
    endtask : rd

    task automatic end_of_test();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // the whole run needs well under a thousand cycles
    initial begin : watchdog
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        end_of_test();
    end

    initial begin
        void'($urandom(32'h4da4));
        {rst_b, done, strobe, clear, hl, code, cause, block} = '0;
        mode = MODE_CONFIG;
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(5'h00);
        check("byte one", d, {24'h0000_00, 3'b000, TYPE_CODE});
        for (int i = 1; i < 4; i++) begin
            rd(ofs[i]);
            check("error byte", d, 32'h0000_0000);
        end
        // health flags follow their inputs bit for bit
        repeat (8) begin
            @(posedge ref_clk);
            hl <= 7'($urandom);
            rd(5'h04);
            check("byte two", d, {24'h0000_00, 1'b0, hl});
        end
        foreach (codes[i]) begin
            if (i < 3) begin
                @(posedge ref_clk);
                mode <= (i == 0) ? MODE_CONFIG : (i == 1) ? MODE_ERROR : MODE_EXEC;
                rd(5'h00);
                check("mode", d, {24'h0000_00, mode == MODE_ERROR, mode, TYPE_CODE});
            end
        end
        rd(5'h04);
        check("first pass", d, {24'h0000_00, 1'b1, hl});
        @(posedge ref_clk);
        done <= 1'b1;
        @(posedge ref_clk);
        done <= 1'b0;
        mode <= MODE_CONFIG;
        rd(5'h04);
        check("first pass end", d, {24'h0000_00, 1'b0, hl});
        // every code, corner block numbers first, writes thrown in mid-way
        foreach (codes[i]) begin
            c = codes[i];
            blk = (i == 4) ? 1024 : (i == 5) ? 9999 : (i == 6) ? 0 : $urandom_range(9999);
            @(posedge ref_clk);
            {strobe, code, block} <= {1'b1, c, 14'(blk)};
            cause <= (i < 4) ? causes[i] : 8'($urandom);
            @(posedge ref_clk);
            strobe <= 1'b0;
            exp_q = (i < 4) ? {causes[i], 8'h00} : (i > 8) ? 16'h0000 : bcd16(blk);
            if (i == 7) begin
                for (int k = 0; k < 5; k++) begin
                    p.access(1'b1, 5'(4 * k), $urandom, d, rsp);
                end
            end
            rd(5'h00);
            check("summary", d, {24'h0000_00, 1'b1, MODE_CONFIG, TYPE_CODE});
            rd(5'h08);
            check("code", d, {24'h0000_00, c});
            rd(5'h0C);
            check("qualifier high", d, {24'h0000_00, exp_q[15:8]});
            rd(OFS_QUAL_LO);
            check("qualifier low", d, {24'h0000_00, exp_q[7:0]});
        end
        rd(5'h10);
        check("unmapped response", {30'h0, rsp}, {30'h0, 2'b10});
        // event and clear in one cycle: the event is kept
        @(posedge ref_clk);
        {strobe, clear, code} <= {2'b11, ERR_DTYPE};
        @(posedge ref_clk);
        {strobe, clear} <= 2'b00;
        rd({1'b0, OFS_CODE});
        check("code kept", d, {24'h00_0000, ERR_DTYPE});
        check("mapped response", {30'h0, rsp}, 32'h0000_0000);
        @(posedge ref_clk);
        clear <= 1'b1;
        @(posedge ref_clk);
        clear <= 1'b0;
        rd(5'h00);
        check("summary cleared", d, {24'h0000_00, 3'b000, TYPE_CODE});
        end_of_test();
    end
endmodule : test_module_status_word_bank
`default_nettype wire

// >>> verilog/module_status_word_bank.sv
// read-only module status word bank on an avalon-mm slave
//
// How it works
// - error summary bit 7 of byte one is 1 when any error exists.
// - mode field bits 6:5 of byte one: 00 config, 01 error, 11 execute.
// - byte one bits 4:0 hold a fixed module type code.
// - first-execute flag set only during the first pass in execute mode.
// - byte two bit 6 is 1 when the backup unit is bad.
// - byte two bits 5 and 4 report remote and local I/O bad.
// - byte two bit 3 is 1 while on-line configuration is in progress.
// - byte two bit 2 is 1 when the nvm checksum check fails.
// - byte two bit 1 is 1 when nvm holds the default configuration.
// - byte two bit 0 is 1 when the digital station is bad.
// - nvm error gives code 01 with the cause in byte four.
// - analog reference error gives code 02 with the block number.
// - missing slave gives code 03 with the slave block number.
// - undefined block reference gives code 05 with referring block number.
// - wrong input data type gives code 06 with referring block number.
// - trip block activation gives code 08 with the trip block number.
// - primary failed with stale backup configuration gives code 0F.
// - primary failed with stale backup dynamic memory gives code 10.
// - block numbers are BCD, byte four high digits, byte five low.
`timescale 1ns/100ps
`default_nettype none

module module_status_word_bank
    import status_word_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_b_i,
    // avalon-mm slave
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic      [1:0]  avs_response_o,
    // module state from the controller core (same clock)
    input  wire logic [1:0]  mode_i,
    input  wire logic        exec_pass_done_i,
    // health inputs from the controller core (same clock)
    input  wire logic        backup_bad_i,
    input  wire logic        remote_io_bad_i,
    input  wire logic        local_io_bad_i,
    input  wire logic        online_cfg_i,
    input  wire logic        nvm_csum_fail_i,
    input  wire logic        nvm_default_i,
    input  wire logic        station_bad_i,
    // error event report: one-cycle strobe with code and qualifier
    input  wire logic        err_strobe_i,
    input  wire logic [7:0]  err_code_i,
    input  wire logic [7:0]  err_cause_i,
    input  wire logic [13:0] err_block_i,
    input  wire logic        err_clear_i
);

    // binary block number 0..9999 to four bcd digits
    function automatic logic [15:0] to_bcd(input logic [13:0] bin);
        logic [29:0] sh;
        sh = {16'h0000, bin};
        for (int i = 0; i < 14; i++) begin
            for (int d = 0; d < 4; d++) begin
                if (sh[14+4*d +: 4] > 4'h4) begin
                    sh[14+4*d +: 4] = sh[14+4*d +: 4] + 4'h3;
                end
            end
            sh = {sh[28:0], 1'b0};
        end
        return sh[29:14];
    endfunction : to_bcd

    // true when the error code carries a block number qualifier
    function automatic logic has_block(input logic [7:0] code);
        return (code == ERR_AIREF) || (code == ERR_MISSING) || (code == ERR_UNDEF)
            || (code == ERR_DTYPE) || (code == ERR_TRIP);
    endfunction : has_block

    logic [7:0]  err_code;
    logic [15:0] err_qual;
    logic        first_execute_flag;
    logic        exec_seen;
    logic [7:0]  byte_one;
    logic [7:0]  byte_two;
    logic        any_error;
    logic        rd_pend;

    // latch the most recent error code and its qualifier; strobe wins over clear
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            err_code <= RST_BYTE;
            err_qual <= RST_BLOCK;
        end else if (err_strobe_i) begin
            err_code <= err_code_i;
            if (err_code_i == ERR_NVM) begin
                err_qual <= {err_cause_i, 8'h00};
            end else if (has_block(err_code_i)) begin
                err_qual <= to_bcd(err_block_i);
            end else begin
                err_qual <= RST_BLOCK;
            end
        end else if (err_clear_i) begin
            err_code <= ERR_NONE;
            err_qual <= RST_BLOCK;
        end
    end

    // first pass in execute: high from entry to execute until the pass ends
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            first_execute_flag       <= 1'b0;
            exec_seen <= 1'b0;
        end else if (mode_i != MODE_EXEC) begin
            first_execute_flag       <= 1'b0;
            exec_seen <= 1'b0;
        end else if (!exec_seen) begin
            first_execute_flag       <= 1'b1;
            exec_seen <= 1'b1;
        end else if (exec_pass_done_i) begin
            first_execute_flag       <= 1'b0;
        end
    end

    // status bytes assembled from live state
    always_comb begin
        any_error = (err_code != ERR_NONE) || (mode_i == MODE_ERROR);
        byte_one  = {any_error, mode_i, TYPE_CODE};
        byte_two  = 8'h00;
        byte_two[POS_FTX] = first_execute_flag;
        byte_two[POS_BAC] = backup_bad_i;
        byte_two[POS_RIO] = remote_io_bad_i;
        byte_two[POS_LIO] = local_io_bad_i;
        byte_two[POS_CFG] = online_cfg_i;
        byte_two[POS_NVF] = nvm_csum_fail_i;
        byte_two[POS_NVI] = nvm_default_i;
        byte_two[POS_DSS] = station_bad_i;
    end

    // one wait state on reads so data come from a flop; writes are ignored
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_pend <= 1'b0;
        end else begin
            rd_pend <= avs_read_i && !rd_pend;
        end
    end

    assign avs_waitrequest_o = avs_read_i && !rd_pend;

    // read data register; writes touch nothing
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            avs_readdata_o <= 32'h0000_0000;
            avs_response_o <= 2'b00;
        end else if (avs_read_i && !rd_pend) begin
            avs_response_o <= 2'b00;
            case (avs_address_i)
                {1'b0, OFS_SUMMARY}: avs_readdata_o <= {24'h00_0000, byte_one};
                {1'b0, OFS_HEALTH}:  avs_readdata_o <= {24'h00_0000, byte_two};
                {1'b0, OFS_CODE}:    avs_readdata_o <= {24'h00_0000, err_code};
                {1'b0, OFS_QUAL_HI}: avs_readdata_o <= {24'h00_0000, err_qual[15:8]};
                OFS_QUAL_LO:         avs_readdata_o <= {24'h00_0000, err_qual[7:0]};
                default: begin
                    avs_readdata_o <= 32'h0000_0000;
                    avs_response_o <= 2'b10;
                end
            endcase
        end
    end

    // true for the five byte addresses that hold status
    function automatic logic addr_mapped(input logic [4:0] a);
        return (a == {1'b0, OFS_SUMMARY}) || (a == {1'b0, OFS_HEALTH})
            || (a == {1'b0, OFS_CODE}) || (a == {1'b0, OFS_QUAL_HI})
            || (a == OFS_QUAL_LO);
    endfunction : addr_mapped

    // read handshake steps: taken in the first cycle, answered in the second
    sequence s_read_taken;
        avs_read_i && !rd_pend;
    endsequence

    sequence s_read_at(logic [4:0] a);
        avs_read_i && !rd_pend && (avs_address_i == a);
    endsequence

    sequence s_read_held;
        avs_read_i && rd_pend;
    endsequence

    // first execute flag rises one cycle after entry to execute
    chk_ftx_first_pass: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (mode_i == MODE_EXEC && $past(mode_i) != MODE_EXEC && $past(rst_b_i))
        |=> first_execute_flag) else $error("first execute flag not raised on entry");
    // flag never survives a cycle outside execute
    chk_ftx_off_mode: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (mode_i != MODE_EXEC) |=> !first_execute_flag) else $error("first execute flag outside exec");
    // end of the first pass drops the flag
    chk_ftx_done: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (first_execute_flag && exec_pass_done_i && mode_i == MODE_EXEC) |=> !first_execute_flag)
        else $error("first execute flag kept after pass");
    // later passes in the same stay in execute never raise it again
    chk_ftx_once: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (exec_seen && !first_execute_flag && mode_i == MODE_EXEC) |=> !first_execute_flag)
        else $error("first execute flag raised twice");
    // nvm cause goes to the high qualifier byte, low byte zero
    chk_nvm_cause: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (err_strobe_i && err_code_i == ERR_NVM)
        |=> err_code == ERR_NVM && err_qual == {$past(err_cause_i), 8'h00})
        else $error("nvm cause not latched");
    // a block number is shown in decimal digits
    chk_bcd_block: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (err_strobe_i && has_block(err_code_i) && err_block_i == 14'd1024)
        |=> err_qual == 16'h1024) else $error("block number not bcd");
    // every digit stays in range for a legal block number
    chk_bcd_digits: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (err_strobe_i && has_block(err_code_i) && err_block_i <= 14'd9999)
        |=> (err_qual[15:12] <= 4'h9) && (err_qual[11:8] <= 4'h9)
            && (err_qual[7:4] <= 4'h9) && (err_qual[3:0] <= 4'h9))
        else $error("bcd digit out of range");
    // redundancy failures carry no qualifier
    chk_no_qualifier: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (err_strobe_i && (err_code_i == ERR_CFG_OLD || err_code_i == ERR_DRAM_OLD))
        |=> err_qual == 16'h0000) else $error("qualifier not zero");
    // nor does any other code without a cause or block
    chk_qual_other_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (err_strobe_i && err_code_i != ERR_NVM && !has_block(err_code_i))
        |=> err_qual == RST_BLOCK) else $error("stray qualifier");
    // the reported code is the one last strobed in
    chk_strobe_code: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        err_strobe_i |=> err_code == $past(err_code_i))
        else $error("error code not latched");
    // an event in the cycle of a clear must not be lost
    chk_strobe_wins: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (err_strobe_i && err_clear_i) |=> err_code == $past(err_code_i))
        else $error("clear beat a new event");
    // a clear alone empties code and qualifier
    chk_clear_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (err_clear_i && !err_strobe_i) |=> err_code == ERR_NONE && err_qual == RST_BLOCK)
        else $error("clear left an error");
    chk_summary_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        byte_one[7] == ((err_code != ERR_NONE) || (mode_i == MODE_ERROR)))
        else $error("error summary wrong");
    chk_type_code: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (byte_one & MASK_TYPE) == {3'b000, TYPE_CODE}) else $error("type code wrong");
    chk_mode_field: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        byte_one[6:5] == mode_i) else $error("mode field wrong");
    // software may poke the bank freely; nothing it writes may stick
    chk_write_inert: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (avs_write_i && !err_strobe_i && !err_clear_i) |=> $stable(err_code) && $stable(err_qual))
        else $error("bus write altered status");
    chk_write_nowait: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (avs_write_i && !avs_read_i) |-> !avs_waitrequest_o)
        else $error("write was stalled");
    // the wait state is what lets read data come from a flop
    chk_read_waits: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_read_taken |-> avs_waitrequest_o) else $error("read answered too early");
    chk_read_answer: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_read_taken |=> !avs_waitrequest_o) else $error("read not answered");
    chk_read_second: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_read_taken ##1 s_read_held |-> !avs_waitrequest_o)
        else $error("held read still waiting");
    // read data checked field by field against the state at the taking edge
    chk_rd_summary: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_read_at({1'b0, OFS_SUMMARY})
        |=> avs_readdata_o[7] == ($past(err_code) != ERR_NONE || $past(mode_i) == MODE_ERROR))
        else $error("summary bit read wrong");
    chk_rd_mode: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_read_at({1'b0, OFS_SUMMARY}) |=> avs_readdata_o[6:5] == $past(mode_i))
        else $error("mode field read wrong");
    chk_rd_type: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_read_at({1'b0, OFS_SUMMARY}) |=> avs_readdata_o[4:0] == TYPE_CODE)
        else $error("type code read wrong");
    chk_rd_upper: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_read_taken |=> avs_readdata_o[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    chk_rd_first_exec: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_read_at({1'b0, OFS_HEALTH}) |=> avs_readdata_o[POS_FTX] == $past(first_execute_flag))
        else $error("first execute bit read wrong");
    chk_rd_backup: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_read_at({1'b0, OFS_HEALTH}) |=> avs_readdata_o[POS_BAC] == $past(backup_bad_i))
        else $error("backup bit read wrong");
    chk_rd_remote_io: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_read_at({1'b0, OFS_HEALTH}) |=> avs_readdata_o[POS_RIO] == $past(remote_io_bad_i))
        else $error("remote io bit read wrong");
    chk_rd_local_io: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_read_at({1'b0, OFS_HEALTH}) |=> avs_readdata_o[POS_LIO] == $past(local_io_bad_i))
        else $error("local io bit read wrong");
    chk_rd_online_cfg: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_read_at({1'b0, OFS_HEALTH}) |=> avs_readdata_o[POS_CFG] == $past(online_cfg_i))
        else $error("online config bit read wrong");
    chk_rd_nvm_fail: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_read_at({1'b0, OFS_HEALTH}) |=> avs_readdata_o[POS_NVF] == $past(nvm_csum_fail_i))
        else $error("checksum bit read wrong");
    chk_rd_nvm_default: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_read_at({1'b0, OFS_HEALTH}) |=> avs_readdata_o[POS_NVI] == $past(nvm_default_i))
        else $error("default config bit read wrong");
    chk_rd_station: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_read_at({1'b0, OFS_HEALTH}) |=> avs_readdata_o[POS_DSS] == $past(station_bad_i))
        else $error("station bit read wrong");
    chk_rd_code: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_read_at({1'b0, OFS_CODE}) |=> avs_readdata_o[7:0] == $past(err_code))
        else $error("error code read wrong");
    chk_rd_qual_high: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_read_at({1'b0, OFS_QUAL_HI}) |=> avs_readdata_o[7:0] == $past(err_qual[15:8]))
        else $error("high qualifier read wrong");
    chk_rd_qual_low: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        s_read_at(OFS_QUAL_LO) |=> avs_readdata_o[7:0] == $past(err_qual[7:0]))
        else $error("low qualifier read wrong");
    // holes in the map answer zero with an error response
    chk_rd_unmapped: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (s_read_taken and !addr_mapped(avs_address_i))
        |=> avs_response_o == 2'b10 && avs_readdata_o == 32'h0000_0000)
        else $error("unmapped read not flagged");
    chk_rd_mapped_ok: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (s_read_taken and addr_mapped(avs_address_i)) |=> avs_response_o == 2'b00)
        else $error("mapped read flagged");
    // answer stands until the next read is taken
    chk_rd_stands: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (!avs_read_i || rd_pend) |=> $stable(avs_readdata_o) && $stable(avs_response_o))
        else $error("read answer changed while idle");

endmodule : module_status_word_bank

`default_nettype wire

// >>> verilog/status_word_pkg.sv
// constants for the five-byte module status word bank
package status_word_pkg;

    // register byte addresses on the avalon bus
    localparam logic [3:0] OFS_SUMMARY  = 4'h0;
    localparam logic [3:0] OFS_HEALTH   = 4'h4;
    localparam logic [3:0] OFS_CODE     = 4'h8;
    localparam logic [3:0] OFS_QUAL_HI  = 4'hC;
    localparam logic [3:0] OFS_CTRL     = 4'h0; // index into second page; the decode does not use it
    localparam logic [4:0] OFS_CTRL_B   = 5'h10;
    localparam logic [4:0] OFS_QUAL_LO  = 5'h14;

    // byte one field masks and positions
    localparam logic [7:0] MASK_ES      = 8'h80;
    localparam int         POS_MODE     = 5;
    localparam logic [7:0] MASK_TYPE    = 8'h1F;
    // module type code, arbitrary neutral value
    localparam logic [4:0] TYPE_CODE    = 5'h15;

    // mode encodings
    localparam logic [1:0] MODE_CONFIG  = 2'h0;
    localparam logic [1:0] MODE_ERROR   = 2'h1;
    localparam logic [1:0] MODE_EXEC    = 2'h3;

    // byte two bit positions
    localparam int POS_FTX  = 7;
    localparam int POS_BAC  = 6;
    localparam int POS_RIO  = 5;
    localparam int POS_LIO  = 4;
    localparam int POS_CFG  = 3;
    localparam int POS_NVF  = 2;
    localparam int POS_NVI  = 1;
    localparam int POS_DSS  = 0;

    // error codes in byte three
    localparam logic [7:0] ERR_NONE     = 8'h00;
    localparam logic [7:0] ERR_NVM      = 8'h01;
    localparam logic [7:0] ERR_AIREF    = 8'h02;
    localparam logic [7:0] ERR_MISSING  = 8'h03;
    localparam logic [7:0] ERR_UNDEF    = 8'h05;
    localparam logic [7:0] ERR_DTYPE    = 8'h06;
    localparam logic [7:0] ERR_TRIP     = 8'h08;
    localparam logic [7:0] ERR_CFG_OLD  = 8'h0F;
    localparam logic [7:0] ERR_DRAM_OLD = 8'h10;

    // nvm cause qualifiers in byte four
    localparam logic [7:0] NVM_WRITE    = 8'h01;
    localparam logic [7:0] NVM_CSUM     = 8'h02;
    localparam logic [7:0] NVM_BADDATA  = 8'h03;
    localparam logic [7:0] NVM_RSTWR    = 8'hFF;

    // reset values
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [15:0] RST_BLOCK   = 16'h0000;

endpackage : status_word_pkg
